// ==== verif/efc_far_end.sv ====
// Far-end model: upstream character link and wide-word link sources.
// Assumes the bench queues items; empty cycles carry fills.
`timescale 1ns/1ps
`default_nettype none

module efc_far_end
  import efc_tb_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  output logic [9:0] rx_char,
  output logic [19:0] ww_word
);

  // Entry: [11] wrong disparity, [10] raw code, [9:0] code or symbol
  logic [11:0] cq[$];
  logic [19:0] wq[$];
  logic [11:0] e;
  logic [9:0] c;
  logic rd;

  task automatic put(input logic [11:0] v);
    cq.push_back(v);
  endtask : put

  task automatic wput(input logic [19:0] v);
    wq.push_back(v);
  endtask : wput

  // Returns once the last item has stood on the pins a full cycle
  task automatic drain;
    while (cq.size() != 0 || wq.size() != 0) @(negedge clock);
    @(negedge clock);
  endtask : drain

  initial begin
    rd = 1'b0;
    rx_char = enc(sym_fill, 1'b0);
    ww_word = 20'h0;
  end

  // One character and one word per clock, changed on the falling edge
  always @(negedge clock) begin
    if (!rst_n) begin
      // Pins hold the first negative fill, so rd is one step ahead
      rx_char = enc(sym_fill, 1'b0);
      rd = rd_char(rx_char, 1'b0);
    end else begin
      e = (cq.size() != 0) ? cq.pop_front() : {3'h0, sym_fill};
      c = e[10] ? e[9:0] : enc(e[8:0], rd ^ e[11]);
      rx_char = c;
      rd = rd_char(c, rd);
    end
    // Fill words: data valid low, pattern toggling so nothing looks held
    ww_word = (wq.size() != 0) ? wq.pop_front() : {4'h0, ~ww_word[15:0]};
  end
  // No test-sequence marker is ever sent

endmodule : efc_far_end
`default_nettype wire

// ==== verif/efc_tb_pkg.sv ====
// Reference character coding for the framing coder bench.
// Assumes only the few characters the bench sends are tabulated.
package efc_tb_pkg;

  // ----------------------------------------
  // Symbols as {control flag, byte}
  // ----------------------------------------
  localparam logic [8:0] sym_fill = 9'h1bc;
  localparam logic [8:0] sym_open = 9'h11c;
  localparam logic [8:0] sym_close = 9'h17c;

  // Majority of ones or zeros decides, a tie keeps the old value
  function automatic logic rd_step(input logic [5:0] v, input int w,
                                   input logic rd);
    int ones;
    ones = $countones(v);
    // The balanced code that flips with disparity counts as excess-ones
    if (w == 6 && v == 6'h38) return 1'b1;
    if (w == 6 && v == 6'h07) return 1'b0;
    if (w == 4 && v == 6'h0c) return 1'b1;
    if (w == 4 && v == 6'h03) return 1'b0;
    if (2 * ones > w) return 1'b1;
    if (2 * ones < w) return 1'b0;
    return rd;
  endfunction : rd_step

  // Low field first, then high field
  function automatic logic rd_char(input logic [9:0] c, input logic rd);
    return rd_step({2'h0, c[3:0]}, 4, rd_step(c[9:4], 6, rd));
  endfunction : rd_char

  // Limitation: only x in 0, 21, 28 and y in 0, 3, 5 are known here
  function automatic logic [9:0] enc(input logic [8:0] s, input logic rd);
    logic [5:0] a;
    logic [3:0] b;
    logic fa, fb, mid;
    case (s[4:0])
      5'h00: {fa, a} = {1'b1, 6'b100111};
      5'h15: {fa, a} = {1'b0, 6'b101010};
      default: {fa, a} = {1'b1, 6'b001111};
    endcase
    case (s[7:5])
      3'h3: {fb, b} = {1'b1, 4'b1100};
      3'h5: {fb, b} = s[8] ? {1'b1, 4'b0101} : {1'b0, 4'b1010};
      default: {fb, b} = {1'b1, 4'b1011};
    endcase
    if (rd && fa) a = ~a;
    mid = rd_step(a, 6, rd);
    if (mid && fb) b = ~b;
    return {a, b};
  endfunction : enc

endpackage : efc_tb_pkg

// ==== verif/efc_top_test.sv ====
// Self-checking bench for the event framing coder.
// Assumes efc_top and the far-end model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module efc_top_test;
  import efc_tb_pkg::*;

  localparam int cycle_limit = 2000;
  logic clock, rst_n, tx_valid, tx_last, tx_ready;
  logic [7:0] tx_data, rx_byte;
  logic [9:0] tx_char, rx_char;
  logic rx_byte_valid, rx_byte_err, rx_open, rx_close, rx_in_event;
  logic rx_aligned, ww_valid, ww_first, ww_last, ww_perr, lost_align;
  logic [19:0] ww_word;
  logic [15:0] ww_data;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_open, n_close, n_perr;
  logic [8:0] rxq[$];
  logic [17:0] wwq[$];

  efc_top dut (.clock, .rst_n, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .tx_char, .rx_char, .rx_byte, .rx_byte_valid, .rx_byte_err, .rx_open,
    .rx_close, .rx_in_event, .rx_aligned, .ww_word, .ww_data, .ww_valid,
    .ww_first, .ww_last, .ww_perr);

  efc_far_end far (.clock, .rst_n, .rx_char, .ww_word);

  // ----------------------------------------
  // Clock, watchdog and output monitor
  // ----------------------------------------
  initial clock = 1'b0;
  always #20 clock = ~clock;

  // A hung handshake must still end the run with a verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == cycle_limit) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge clock) begin
    if (rx_byte_valid === 1'b1) rxq.push_back({rx_byte_err, rx_byte});
    if (rx_open === 1'b1) n_open++;
    if (rx_close === 1'b1) n_close++;
    if (rx_aligned !== 1'b1) lost_align = 1'b1;
    if (ww_valid === 1'b1) wwq.push_back({ww_first, ww_last, ww_data});
    if (ww_perr === 1'b1) n_perr++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Settle after a rising edge before looking at outputs
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
    @(posedge clock);
    #1;
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset: outputs quiet, then fills starting at negative disparity
  task automatic do_reset;
    logic rd;
    @(negedge clock);
    rst_n <= 1'b0;
    repeat (6) @(negedge clock);
    chk(20'(tx_char), 20'h0);
    chk(20'({tx_ready, rx_in_event, ww_valid}), 20'h0);
    // Non-blocking, so the far end still sees reset at this edge
    rst_n <= 1'b1;
    rd = 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1;
      chk(20'(tx_char), 20'(enc(sym_fill, rd)));
      rd = rd_char(enc(sym_fill, rd), rd);
    end
  endtask : do_reset

  // Two bytes back to back, then the close framing
  task automatic t_tx_frame;
    logic [9:0] got[0:23];
    logic [8:0] seq[0:14];
    logic [9:0] e;
    logic take, rd;
    int n, j;
    seq = '{sym_open, 9'h000, 9'h0b5, sym_fill, sym_fill, sym_fill,
      sym_fill, sym_fill, sym_close, sym_fill, sym_fill, sym_fill,
      sym_fill, sym_fill, sym_fill};
    n = 0;
    take = 1'b0;
    for (int i = 0; i < 25; i++) begin
      @(negedge clock);
      if (i > 0) got[i-1] = tx_char;
      if (take) n++;
      if (i == 0 || take) begin
        tx_valid = (n < 2);
        tx_data = (n == 0) ? 8'h00 : 8'hb5;
        tx_last = (n == 1);
      end
      take = tx_valid & tx_ready;
    end
    rd = (got[0] === enc(sym_fill, 1'b1));
    j = 0;
    while (j < 6 && got[j] === enc(sym_fill, rd)) begin
      rd = rd_char(got[j], rd);
      j++;
    end
    for (int k = 0; k < 15; k++) begin
      e = enc(seq[k], rd);
      chk(20'(got[j+k]), 20'(e));
      rd = rd_char(e, rd);
    end
  endtask : t_tx_frame

  // Receive: idle junk, fills and errors inside an event
  task automatic t_rx_frame;
    logic [9:0] bad;
    settle(6);
    rxq.delete();
    n_open = 0;
    n_close = 0;
    lost_align = 1'b0;
    chk(20'(rx_aligned), 20'h1);
    far.put({3'h0, 9'h0b5});  // Valid data while idle is dropped
    far.put({3'h0, sym_close});  // Close while idle is ignored
    far.put({3'h0, sym_open});
    far.put({3'h0, 9'h000});
    far.put({3'h0, sym_fill});
    far.put({3'h0, 9'h0b5});
    far.drain();
    settle(4);
    chk(20'(rx_in_event), 20'h1);
    far.put({2'h1, 10'h000});  // Invalid pattern kept in event
    far.put({3'h4, 9'h000});  // Wrong disparity
    far.put({3'h0, sym_close});
    far.drain();
    settle(6);
    bad = enc(9'h000, 1'b1);
    chk(20'(rxq.size()), 20'h4);
    chk(20'(rxq[0]), 20'h000);
    chk(20'(rxq[1]), 20'h0b5);
    chk(20'(rxq[2]), 20'h100);
    chk(20'(rxq[3]), 20'({1'b1, bad[7:0]}));
    chk(20'({n_open[3:0], n_close[3:0]}), 20'h11);
    chk(20'({rx_in_event, lost_align, rx_aligned}), 20'h3);
  endtask : t_rx_frame

  // Wide words: open, stray open, data, error, fill, close, late error
  task automatic t_ww_frame;
    settle(1);
    wwq.delete();
    n_perr = 0;
    far.wput({4'h9, 16'h1234});  // Open bit, 16 data bits
    far.wput({4'h9, 16'h5555});  // Open bit inside event dropped, flagged
    far.wput({4'h8, 16'h0000});
    far.wput({4'hc, 16'hdead});
    far.wput({4'h0, 16'hffff});
    far.wput({4'ha, 16'hbeef});  // Close bit
    far.wput({4'hc, 16'h0bad});  // Error word while idle
    far.wput({4'hb, 16'h0f0f});  // Both marker bits: opens, flagged
    far.wput({4'ha, 16'hf0f0});
    far.drain();
    settle(5);
    chk(20'(wwq.size()), 20'h5);
    chk(20'(wwq[0]), 20'h21234);
    chk(20'(wwq[1]), 20'h00000);
    chk(20'(wwq[2]), 20'h1beef);
    chk(20'(wwq[3]), 20'h20f0f);
    chk(20'(wwq[4]), 20'h1f0f0);
    chk(20'(n_perr), 20'h4);
  endtask : t_ww_frame

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    do_reset();
    t_tx_frame();
    t_rx_frame();
    t_ww_frame();
    do_reset();
    t_rx_frame();
    wrap_up();
  end

endmodule : efc_top_test
`default_nettype wire

// ==== verilog/efc_params.svh ====
// Timing counts and control codes for the event framing coder.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH

// Control characters all sit in the K28 group; only the high field varies
`define EFC_K_LOW 5'h1c
`define EFC_FILL_Y 3'h5
`define EFC_OPEN_Y 3'h0
`define EFC_CLOSE_Y 3'h3

// Fill characters on each side of the close marker
`define EFC_CLOSE_GAP 3'h5
// Consecutive fills that restore character alignment
`define EFC_SYNC_FILLS 2'h2

// Wide-word lane positions (16 data, open bit, close bit, error, data valid)
`define EFC_WW_OPEN_BIT 16
`define EFC_WW_CLOSE_BIT 17
`define EFC_WW_ERR_BIT 18
`define EFC_WW_DV_BIT 19

`endif

// ==== verilog/efc_pkg.sv ====
// Types shared by the event framing coder.
// Assumes efc_params.svh is on the include path.
`include "efc_params.svh"

package efc_pkg;

  // Transmit framing states, Gray coded from idle to post; post back to idle flips all three bits
  typedef enum logic [2:0] {
    EFC_TX_IDLE = 3'h0,
    EFC_TX_OPEN = 3'h1,
    EFC_TX_DATA = 3'h3,
    EFC_TX_PRE = 3'h2,
    EFC_TX_CLOSE = 3'h6,
    EFC_TX_POST = 3'h7
  } efc_tx_t;

  // Receive event machine
  typedef enum logic {
    EFC_EV_IDLE = 1'b0,
    EFC_EV_IN = 1'b1
  } efc_ev_t;

  // Whole state of the block
  typedef struct packed {
    efc_tx_t tx_st;
    logic [2:0] tx_cnt;
    logic tx_rd;
    logic [9:0] tx_char;
    logic tx_ready;
    logic [9:0] rx_s1;
    logic [9:0] rx_s2;
    logic rx_rd;
    efc_ev_t rx_st;
    logic [1:0] fill_run;
    logic rx_aligned;
    logic [7:0] rx_byte;
    logic rx_byte_valid;
    logic rx_byte_err;
    logic rx_open;
    logic rx_close;
    logic [19:0] ww_s1;
    logic [19:0] ww_s2;
    efc_ev_t ww_st;
    logic [15:0] ww_data;
    logic ww_valid;
    logic ww_first;
    logic ww_last;
    logic ww_perr;
  } efc_state_t;

endpackage : efc_pkg

// ==== verilog/efc_top.sv ====
// Event framing coder: character-link framer with 8b/10b encoder,
// character-link receiver with decoder and event machine, and a
// wide-word link receiver with in-band open and close bits.
// Assumes one parallel word clock; link pins come from other domains.
`timescale 1ns/1ps
`default_nettype none
`include "efc_params.svh"

module efc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [9:0] tx_char,
  input wire logic [9:0] rx_char,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_byte_err,
  output logic rx_open,
  output logic rx_close,
  output logic rx_in_event,
  output logic rx_aligned,
  input wire logic [19:0] ww_word,
  output logic [15:0] ww_data,
  output logic ww_valid,
  output logic ww_first,
  output logic ww_last,
  output logic ww_perr
);
  import efc_pkg::*;

  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------

  // 6-bit low field, negative disparity form, sent as abcdei
  function automatic logic [5:0] enc6(input logic [4:0] v, input logic rd,
                                      input logic k);
    logic [5:0] c;
    logic unb;
    c = 6'h00;
    case (v)
      5'h00: c = 6'h27; 5'h01: c = 6'h1d; 5'h02: c = 6'h2d; 5'h03: c = 6'h31;
      5'h04: c = 6'h35; 5'h05: c = 6'h29; 5'h06: c = 6'h19; 5'h07: c = 6'h38;
      5'h08: c = 6'h39; 5'h09: c = 6'h25; 5'h0a: c = 6'h15; 5'h0b: c = 6'h34;
      5'h0c: c = 6'h0d; 5'h0d: c = 6'h2c; 5'h0e: c = 6'h1c; 5'h0f: c = 6'h17;
      5'h10: c = 6'h1b; 5'h11: c = 6'h23; 5'h12: c = 6'h13; 5'h13: c = 6'h32;
      5'h14: c = 6'h0b; 5'h15: c = 6'h2a; 5'h16: c = 6'h1a; 5'h17: c = 6'h3a;
      5'h18: c = 6'h33; 5'h19: c = 6'h26; 5'h1a: c = 6'h16; 5'h1b: c = 6'h36;
      5'h1c: c = 6'h0e; 5'h1d: c = 6'h2e; 5'h1e: c = 6'h1e; 5'h1f: c = 6'h2b;
      default: c = 6'h00;
    endcase
    if (k) begin
      c = 6'h0f;
    end
    // The one balanced excess-ones code flips like the unbalanced ones
    unb = ($countones(c) != 3) || (c == 6'h38);
    return (rd && unb) ? ~c : c;
  endfunction : enc6

  // 4-bit high field, sent as fghj
  function automatic logic [3:0] enc4(input logic [2:0] v, input logic rd,
                                      input logic k);
    logic [3:0] c;
    logic unb;
    c = 4'h0;
    case ({k, v})
      4'h0: c = 4'hb; 4'h1: c = 4'h9; 4'h2: c = 4'h5; 4'h3: c = 4'hc;
      4'h4: c = 4'hd; 4'h5: c = 4'ha; 4'h6: c = 4'h6; 4'h7: c = 4'he;
      4'h8: c = 4'hb; 4'h9: c = 4'h6; 4'ha: c = 4'ha; 4'hb: c = 4'hc;
      4'hc: c = 4'hd; 4'hd: c = 4'h5; 4'he: c = 4'h9; 4'hf: c = 4'h7;
      default: c = 4'h0;
    endcase
    unb = k || ($countones(c) != 2) || (c == 4'hc);
    return (rd && unb) ? ~c : c;
  endfunction : enc4

  // Disparity after a low-field symbol, valid or not
  function automatic logic rd6(input logic [5:0] c, input logic rd);
    if (($countones(c) > 3) || (c == 6'h38)) begin
      return 1'b1;
    end else if (($countones(c) < 3) || (c == 6'h07)) begin
      return 1'b0;
    end
    return rd;
  endfunction : rd6

  // Disparity after a high-field symbol, valid or not
  function automatic logic rd4(input logic [3:0] c, input logic rd);
    if (($countones(c) > 2) || (c == 4'hc)) begin
      return 1'b1;
    end else if (($countones(c) < 2) || (c == 4'h3)) begin
      return 1'b0;
    end
    return rd;
  endfunction : rd4

  // Full character: low symbol then high symbol, both steps of disparity
  function automatic logic [10:0] enc10(input logic [7:0] b,
                                        input logic k, input logic rd);
    logic [5:0] a6;
    logic [3:0] b4;
    logic rdm;
    a6 = enc6(b[4:0], rd, k);
    rdm = rd6(a6, rd);
    b4 = enc4(b[7:5], rdm, k);
    return {rd4(b4, rdm), a6, b4};
  endfunction : enc10

  // Decode to {valid, control, byte}; valid only for this disparity
  function automatic logic [9:0] dec10(input logic [9:0] c, input logic rd);
    logic rdm;
    logic h6;
    logic h4;
    logic k;
    logic [4:0] v5;
    logic [2:0] v3;
    rdm = rd6(c[9:4], rd);
    h6 = 1'b0;
    h4 = 1'b0;
    v5 = 5'h00;
    v3 = 3'h0;
    k = (c[9:4] == enc6(5'h00, rd, 1'b1));
    for (int i = 0; i < 32; i++) begin
      if (enc6(5'(i), rd, 1'b0) == c[9:4]) begin
        h6 = 1'b1;
        v5 = 5'(i);
      end
    end
    if (k) begin
      v5 = `EFC_K_LOW;
    end
    for (int j = 0; j < 8; j++) begin
      if (enc4(3'(j), rdm, k) == c[3:0]) begin
        h4 = 1'b1;
        v3 = 3'(j);
      end
    end
    return {(h6 || k) && h4, k, v3, v5};
  endfunction : dec10

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  efc_state_t s;
  efc_state_t next_s;
  logic [9:0] rx_dec;
  logic rx_err;
  logic rx_is_fill;
  logic rx_is_open;
  logic rx_is_close;
  logic tx_take;
  logic ww_err_in;
  logic tx_in_pre;
  logic tx_in_close;
  logic tx_in_post;

  // Receive decode of the synchronised character
  assign rx_dec = dec10(s.rx_s2, s.rx_rd);
  assign rx_err = !rx_dec[9];
  assign rx_is_fill = rx_dec[9] && rx_dec[8] && (rx_dec[7:5] == `EFC_FILL_Y);
  assign rx_is_open = rx_dec[9] && rx_dec[8] && (rx_dec[7:5] == `EFC_OPEN_Y);
  assign rx_is_close = rx_dec[9] && rx_dec[8] &&
                       (rx_dec[7:5] == `EFC_CLOSE_Y);
  assign tx_take = (s.tx_st == EFC_TX_DATA) && s.tx_ready && tx_valid;
  assign ww_err_in = s.ww_s2[`EFC_WW_ERR_BIT];
  assign tx_in_pre = (s.tx_st == EFC_TX_PRE);
  assign tx_in_close = (s.tx_st == EFC_TX_CLOSE);
  assign tx_in_post = (s.tx_st == EFC_TX_POST);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] tb;
    logic tk;
    logic [10:0] te;
    logic dv;
    next_s = s;
    tb = {`EFC_FILL_Y, `EFC_K_LOW};
    tk = 1'b1;
    te = 11'h000;
    dv = 1'b0;

    // Transmit framing; every state emits one character per clock
    case (s.tx_st)
      EFC_TX_IDLE: begin
        if (tx_valid) begin
          next_s.tx_st = EFC_TX_OPEN;
        end
      end
      EFC_TX_OPEN: begin
        tb = {`EFC_OPEN_Y, `EFC_K_LOW};
        next_s.tx_st = EFC_TX_DATA;
      end
      EFC_TX_DATA: begin
        // A gap from the source becomes fill inside the event
        if (tx_take) begin
          tb = tx_data;
          tk = 1'b0;
          if (tx_last) begin
            next_s.tx_st = EFC_TX_PRE;
            next_s.tx_cnt = 3'h0;
          end
        end
      end
      EFC_TX_PRE: begin
        next_s.tx_cnt = s.tx_cnt + 3'h1;
        if (s.tx_cnt == `EFC_CLOSE_GAP - 3'h1) begin
          next_s.tx_st = EFC_TX_CLOSE;
        end
      end
      EFC_TX_CLOSE: begin
        tb = {`EFC_CLOSE_Y, `EFC_K_LOW};
        next_s.tx_st = EFC_TX_POST;
        next_s.tx_cnt = 3'h0;
      end
      EFC_TX_POST: begin
        next_s.tx_cnt = s.tx_cnt + 3'h1;
        if (s.tx_cnt == `EFC_CLOSE_GAP - 3'h1) begin
          next_s.tx_st = EFC_TX_IDLE;
        end
      end
      default: begin
        next_s.tx_st = EFC_TX_IDLE;
      end
    endcase
    te = enc10(tb, tk, s.tx_rd);
    next_s.tx_char = te[9:0];
    next_s.tx_rd = te[10];
    // Ready only while the data state lasts, so a last byte stops it
    next_s.tx_ready = (next_s.tx_st == EFC_TX_DATA);

    // Link pin synchronisers
    next_s.rx_s1 = rx_char;
    next_s.rx_s2 = s.rx_s1;
    next_s.ww_s1 = ww_word;
    next_s.ww_s2 = s.ww_s1;

    // Receive disparity tracks whatever arrives, invalid symbols too
    next_s.rx_rd = rd4(s.rx_s2[3:0], rd6(s.rx_s2[9:4], s.rx_rd));

    // Alignment: lost on an error, regained after two fills
    if (rx_err) begin
      next_s.fill_run = 2'h0;
      next_s.rx_aligned = 1'b0;
    end else if (rx_is_fill) begin
      if (s.fill_run != `EFC_SYNC_FILLS) begin
        next_s.fill_run = s.fill_run + 2'h1;
      end
      if (s.fill_run == `EFC_SYNC_FILLS - 2'h1) begin
        next_s.rx_aligned = 1'b1;
      end
    end else begin
      next_s.fill_run = 2'h0;
    end

    // Receive event machine and payload filter
    next_s.rx_byte_valid = 1'b0;
    next_s.rx_byte_err = 1'b0;
    next_s.rx_open = 1'b0;
    next_s.rx_close = 1'b0;
    case (s.rx_st)
      EFC_EV_IDLE: begin
        // Anything but open is dropped, test marker too
        if (rx_is_open) begin
          next_s.rx_st = EFC_EV_IN;
          next_s.rx_open = 1'b1;
        end
      end
      EFC_EV_IN: begin
        if (rx_is_close) begin
          next_s.rx_st = EFC_EV_IDLE;
          next_s.rx_close = 1'b1;
        end else if (rx_err) begin
          next_s.rx_byte_valid = 1'b1;
          next_s.rx_byte_err = 1'b1;
          next_s.rx_byte = s.rx_s2[7:0];
        end else if (!rx_dec[8]) begin
          next_s.rx_byte_valid = 1'b1;
          next_s.rx_byte = rx_dec[7:0];
        end
        // Fills and other controls are consumed without output
      end
      default: begin
        next_s.rx_st = EFC_EV_IDLE;
      end
    endcase

    // Wide-word receiver
    dv = s.ww_s2[`EFC_WW_DV_BIT] && !ww_err_in;
    next_s.ww_valid = 1'b0;
    next_s.ww_first = 1'b0;
    next_s.ww_last = 1'b0;
    next_s.ww_perr = ww_err_in;
    next_s.ww_data = s.ww_s2[15:0];
    if (dv) begin
      case (s.ww_st)
        EFC_EV_IDLE: begin
          // Any data word opens; a missing open bit is a protocol fault
          next_s.ww_valid = 1'b1;
          next_s.ww_first = 1'b1;
          next_s.ww_st = EFC_EV_IN;
          next_s.ww_perr = !s.ww_s2[`EFC_WW_OPEN_BIT] ||
                           s.ww_s2[`EFC_WW_CLOSE_BIT];
        end
        EFC_EV_IN: begin
          if (s.ww_s2[`EFC_WW_OPEN_BIT]) begin
            next_s.ww_perr = 1'b1;
          end else begin
            next_s.ww_valid = 1'b1;
            if (s.ww_s2[`EFC_WW_CLOSE_BIT]) begin
              next_s.ww_last = 1'b1;
              next_s.ww_st = EFC_EV_IDLE;
            end
          end
        end
        default: begin
          next_s.ww_st = EFC_EV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign tx_ready = s.tx_ready;
  assign tx_char = s.tx_char;
  assign rx_byte = s.rx_byte;
  assign rx_byte_valid = s.rx_byte_valid;
  assign rx_byte_err = s.rx_byte_err;
  assign rx_open = s.rx_open;
  assign rx_close = s.rx_close;
  assign rx_in_event = s.rx_st;
  assign rx_aligned = s.rx_aligned;
  assign ww_data = s.ww_data;
  assign ww_valid = s.ww_valid;
  assign ww_first = s.ww_first;
  assign ww_last = s.ww_last;
  assign ww_perr = s.ww_perr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence pre_fills;
    tx_in_pre [*5];
  endsequence
  sequence post_fills;
    tx_in_post [*5];
  endsequence

  idle_sends_fill_a: assert property ((s.tx_st == EFC_TX_IDLE) |=>
    (dec10(s.tx_char, $past(s.tx_rd)) == {2'b11, `EFC_FILL_Y, `EFC_K_LOW}))
    else $error("idle transmitter sent a non-fill character");
  close_pre_gap_a: assert property ($rose(tx_in_pre) |->
    pre_fills ##1 tx_in_close)
    else $error("close marker not preceded by five fills");
  close_post_gap_a: assert property (tx_in_close |=> post_fills)
    else $error("close marker not followed by five fills");
  byte_encodes_a: assert property (tx_take |=>
    (dec10(s.tx_char, $past(s.tx_rd)) == {2'b10, $past(tx_data)}))
    else $error("encoded character does not decode to the byte");
  tx_rd_track_a: assert property (1'b1 |=> (s.tx_rd ==
    rd4(s.tx_char[3:0], rd6(s.tx_char[9:4], $past(s.tx_rd)))))
    else $error("transmit disparity disagrees with sent symbols");
  rx_open_enter_a: assert property ((!s.rx_st && rx_is_open) |=>
    (s.rx_st && s.rx_open))
    else $error("open marker did not enter the event");
  rx_fill_drop_a: assert property (rx_is_fill |=> !s.rx_byte_valid)
    else $error("fill character delivered as payload");
  rx_err_keep_a: assert property ((s.rx_st && rx_err) |=>
    (s.rx_byte_valid && s.rx_byte_err))
    else $error("in-event error character not kept and flagged");
  rx_idle_drop_a: assert property (!s.rx_st |=> !s.rx_byte_valid)
    else $error("character delivered outside an event");
  rx_align_a: assert property ((rx_is_fill ##1 rx_is_fill) |=>
    s.rx_aligned)
    else $error("alignment not regained after two fills");
  ww_err_drop_a: assert property (ww_err_in |=> !s.ww_valid)
    else $error("erroneous wide word delivered");
  ww_mark_excl_a: assert property ((!ww_err_in &&
    s.ww_s2[`EFC_WW_DV_BIT] && s.ww_s2[`EFC_WW_OPEN_BIT] &&
    s.ww_s2[`EFC_WW_CLOSE_BIT]) |=> s.ww_perr)
    else $error("word with both marker bits not flagged");

endmodule : efc_top

`default_nettype wire
